// [lvsc_regs.vh]
// Register map, field positions and reset values of the supply supervisor
`ifndef LVSC_REGS_VH
`define LVSC_REGS_VH

// ****************
// Byte addresses
// ****************
`define LVSC_ADDR_W 8
`define LVSC_OFF_CTRL1 8'h00
`define LVSC_OFF_CTRL2 8'h04
`define LVSC_OFF_ISTAT 8'h08
`define LVSC_OFF_IMASK 8'h0c
`define LVSC_OFF_STATE 8'h10

// ****************
// First register fields
// ****************
`define LVSC_C1_WFLAG 7
`define LVSC_C1_WACK 6
`define LVSC_C1_WIE 5
`define LVSC_C1_DRE 4
`define LVSC_C1_DSE 3
`define LVSC_C1_DE 2
`define LVSC_C1_REFERENCE_BUFFER_ENABLE 0

// ****************
// Second register fields
// ****************
`define LVSC_C2_DV 5
`define LVSC_C2_WV 4
`define LVSC_C2_PARTIAL_POWERDOWN_FLAG 3
`define LVSC_C2_PARTIAL_POWERDOWN_ACK 2
`define LVSC_C2_PARTIAL_POWERDOWN_CONTROL 0

// ****************
// Reset values
// ****************
`define LVSC_RST_WIE 1'b0
`define LVSC_RST_DRE 1'b1
`define LVSC_RST_DSE 1'b1
`define LVSC_RST_DE 1'b1
`define LVSC_RST_REFERENCE_BUFFER_ENABLE 1'b0
`define LVSC_RST_DV 1'b0
`define LVSC_RST_WV 1'b0
`define LVSC_RST_PARTIAL_POWERDOWN_CONTROL 1'b0

// ****************
// Interrupt status bits
// ****************
`define LVSC_IRQ_W 3
`define LVSC_IRQ_WARN 0
`define LVSC_IRQ_DET 1
`define LVSC_IRQ_PPD 2

// ****************
// Stop state field
// ****************
`define LVSC_ST_W 2

`endif

// [lvsc_sync.v]
// Two-flop synchroniser for asynchronous comparator levels
`default_nettype none

module lvsc_sync #(
	parameter W = 2
) (
	input wire hclk,
	input wire hresetn,
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);

reg [W-1:0] meta_q;

// First stage feeds only the second stage
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		meta_q <= {W{1'b0}};
		sync_out <= {W{1'b0}};
	end else begin
		meta_q <= async_in;
		sync_out <= meta_q;
	end
end

endmodule // lvsc_sync
`default_nettype wire

// [lvsc_wonce.v]
// Control bit that accepts only the first write after reset
`default_nettype none

module lvsc_wonce #(
	parameter [0:0] RST = 1'b0
) (
	input wire hclk,
	input wire hresetn,
	input wire wr,
	input wire d,
	output reg q
);

reg locked_q;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		q <= RST;
		locked_q <= 1'b0;
	end else if (wr && !locked_q) begin
		q <= d;
		locked_q <= 1'b1;
	end
end

endmodule // lvsc_wonce
`default_nettype wire

// [lvsc_top.v]
// Low-voltage supervision and stop-mode control with AHB-Lite registers
//
// Added by the designer: the AHB-Lite slave port and the address map.
`include "lvsc_regs.vh"
`default_nettype none

// Behaviour
// - Warning flag sets while supply below warning
// - Warning ack clears flag only if gone
// - Warning enable raises request while flag set
// - Detect reset enable forces reset when enabled
// - Detect stop enable keeps detect in stop
// - Detect enable gates detect logic and qualifiers
// - Bit zero enables reference buffer
// - Write-once bits take first write only
// - Detect level select picks trip range
// - Warning level select picks point within range
// - Partial power-down flag reads one after stop2
// - Writing ack clears partial power-down flag
// - Power-down control selects stop2 or stop3
module lvsc_top (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire supply_warning_cmp,
	input wire supply_detect_cmp,
	input wire stop_request,
	input wire stop_wakeup,
	output reg supply_warning_irq,
	output reg supply_detect_reset,
	output reg reference_buffer_enable,
	output reg [1:0] trip_select,
	output reg supply_detect_active,
	output reg stop2_active,
	output reg stop3_active,
	output reg irq
);

// ****************
// Stop state codes
// ****************
localparam [`LVSC_ST_W-1:0] ST_RUN = 2'h0;
localparam [`LVSC_ST_W-1:0] ST_STOP3 = 2'h1;
localparam [`LVSC_ST_W-1:0] ST_STOP2 = 2'h2;

// ****************
// Bus phase tracking
// ****************
reg wr_pend_q;
reg rd_pend_q;
reg [`LVSC_ADDR_W-1:0] addr_q;
wire addr_phase;
wire wr_c1;
wire wr_c2;
wire wr_ist;
wire wr_imk;

// Only whole-word transfers reach this slave, so hsize is not decoded
assign addr_phase = hsel && htrans[1] && hready;
assign wr_c1 = wr_pend_q && (addr_q == `LVSC_OFF_CTRL1);
assign wr_c2 = wr_pend_q && (addr_q == `LVSC_OFF_CTRL2);
assign wr_ist = wr_pend_q && (addr_q == `LVSC_OFF_ISTAT);
assign wr_imk = wr_pend_q && (addr_q == `LVSC_OFF_IMASK);

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_q <= 1'b0;
		rd_pend_q <= 1'b0;
		addr_q <= {`LVSC_ADDR_W{1'b0}};
	end else begin
		wr_pend_q <= addr_phase && hwrite;
		rd_pend_q <= addr_phase && !hwrite;
		if (addr_phase) begin
			addr_q <= haddr[`LVSC_ADDR_W-1:0];
		end
	end
end

// ****************
// Comparator inputs
// ****************
wire [1:0] cmp_s;
wire warn_s;
wire det_s;

lvsc_sync #(
	.W(2)
) u_sync (
	.hclk(hclk),
	.hresetn(hresetn),
	.async_in({supply_detect_cmp, supply_warning_cmp}),
	.sync_out(cmp_s)
);
assign warn_s = cmp_s[0];
assign det_s = cmp_s[1];

// ****************
// Write-once controls
// ****************
wire supply_detect_reset_enable;
wire supply_detect_enable;
wire supply_detect_level_select;
wire partial_powerdown_control;

lvsc_wonce #(
	.RST(`LVSC_RST_DRE)
) u_wo_dre (
	.hclk(hclk),
	.hresetn(hresetn),
	.wr(wr_c1),
	.d(hwdata[`LVSC_C1_DRE]),
	.q(supply_detect_reset_enable)
);

lvsc_wonce #(
	.RST(`LVSC_RST_DE)
) u_wo_de (
	.hclk(hclk),
	.hresetn(hresetn),
	.wr(wr_c1),
	.d(hwdata[`LVSC_C1_DE]),
	.q(supply_detect_enable)
);

lvsc_wonce #(
	.RST(`LVSC_RST_DV)
) u_wo_dv (
	.hclk(hclk),
	.hresetn(hresetn),
	.wr(wr_c2),
	.d(hwdata[`LVSC_C2_DV]),
	.q(supply_detect_level_select)
);

lvsc_wonce #(
	.RST(`LVSC_RST_PARTIAL_POWERDOWN_CONTROL)
) u_wo_partial_powerdown_control (
	.hclk(hclk),
	.hresetn(hresetn),
	.wr(wr_c2),
	.d(hwdata[`LVSC_C2_PARTIAL_POWERDOWN_CONTROL]),
	.q(partial_powerdown_control)
);

// ****************
// Read/write controls
// ****************
reg low_supply_warning_irq_enable_q;
reg supply_detect_stop_enable_q;
reg reference_buffer_enable_q;
reg supply_warning_level_select_q;
reg [`LVSC_IRQ_W-1:0] imask_q;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		low_supply_warning_irq_enable_q <= `LVSC_RST_WIE;
		supply_detect_stop_enable_q <= `LVSC_RST_DSE;
		reference_buffer_enable_q <= `LVSC_RST_REFERENCE_BUFFER_ENABLE;
		supply_warning_level_select_q <= `LVSC_RST_WV;
		imask_q <= {`LVSC_IRQ_W{1'b0}};
	end else begin
		if (wr_c1) begin
			low_supply_warning_irq_enable_q <= hwdata[`LVSC_C1_WIE];
			supply_detect_stop_enable_q <= hwdata[`LVSC_C1_DSE];
			reference_buffer_enable_q <= hwdata[`LVSC_C1_REFERENCE_BUFFER_ENABLE];
		end
		if (wr_c2) begin
			supply_warning_level_select_q <= hwdata[`LVSC_C2_WV];
		end
		if (wr_imk) begin
			imask_q <= hwdata[`LVSC_IRQ_W-1:0];
		end
	end
end

// ****************
// Stop mode sequencing
// ****************
reg [`LVSC_ST_W-1:0] st_q;
reg [`LVSC_ST_W-1:0] st_d;
wire stop2_wake;

always @* begin
	st_d = st_q;
	case (st_q)
		ST_RUN: begin
			if (stop_request) begin
				st_d = partial_powerdown_control ? ST_STOP2 : ST_STOP3;
			end
		end
		ST_STOP3: begin
			if (stop_wakeup) begin
				st_d = ST_RUN;
			end
		end
		ST_STOP2: begin
			if (stop_wakeup) begin
				st_d = ST_RUN;
			end
		end
		default: begin
			st_d = ST_RUN;
		end
	endcase
end

assign stop2_wake = (st_q == ST_STOP2) && stop_wakeup;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		st_q <= ST_RUN;
	end else begin
		st_q <= st_d;
	end
end

// ****************
// Detect and warning logic
// ****************
wire in_stop;
wire det_live;
wire det_event;
reg low_supply_warning_flag_q;
reg partial_powerdown_flag_q;
reg warn_flag_prev_q;
reg det_prev_q;

assign in_stop = (st_q != ST_RUN);
assign det_live = supply_detect_enable && (!in_stop || supply_detect_stop_enable_q);
assign det_event = det_live && det_s;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		low_supply_warning_flag_q <= 1'b0;
		partial_powerdown_flag_q <= 1'b0;
		warn_flag_prev_q <= 1'b0;
		det_prev_q <= 1'b0;
	end else begin
		warn_flag_prev_q <= low_supply_warning_flag_q;
		det_prev_q <= det_event;
		if (warn_s) begin
			low_supply_warning_flag_q <= 1'b1;
		end else if (wr_c1 && hwdata[`LVSC_C1_WACK]) begin
			low_supply_warning_flag_q <= 1'b0;
		end
		if (stop2_wake) begin
			partial_powerdown_flag_q <= 1'b1;
		end else if (wr_c2 && hwdata[`LVSC_C2_PARTIAL_POWERDOWN_ACK]) begin
			partial_powerdown_flag_q <= 1'b0;
		end
	end
end

// ****************
// Interrupt status
// ****************
reg [`LVSC_IRQ_W-1:0] istat_q;
wire [`LVSC_IRQ_W-1:0] ev;

assign ev[`LVSC_IRQ_WARN] = low_supply_warning_flag_q && !warn_flag_prev_q;
assign ev[`LVSC_IRQ_DET] = det_event && !det_prev_q;
assign ev[`LVSC_IRQ_PPD] = stop2_wake;

// Set wins over a same-cycle write-one clear
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		istat_q <= {`LVSC_IRQ_W{1'b0}};
	end else if (wr_ist) begin
		istat_q <= ev | (istat_q & ~hwdata[`LVSC_IRQ_W-1:0]);
	end else begin
		istat_q <= istat_q | ev;
	end
end

// ****************
// Registered outputs
// ****************
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		supply_warning_irq <= 1'b0;
		supply_detect_reset <= 1'b0;
		reference_buffer_enable <= 1'b0;
		trip_select <= 2'h0;
		supply_detect_active <= 1'b0;
		stop2_active <= 1'b0;
		stop3_active <= 1'b0;
		irq <= 1'b0;
	end else begin
		supply_warning_irq <= low_supply_warning_irq_enable_q && low_supply_warning_flag_q;
		supply_detect_reset <= det_event && supply_detect_reset_enable;
		reference_buffer_enable <= reference_buffer_enable_q;
		trip_select <= {supply_detect_level_select, supply_warning_level_select_q};
		supply_detect_active <= det_live;
		stop2_active <= (st_d == ST_STOP2);
		stop3_active <= (st_d == ST_STOP3);
		irq <= |(istat_q & imask_q);
	end
end

// ****************
// Read path
// ****************
reg [31:0] rdata_d;

// Unmapped addresses read zero
always @* begin
	rdata_d = 32'h0000_0000;
	if (addr_q == `LVSC_OFF_CTRL1) begin
		rdata_d[`LVSC_C1_WFLAG] = low_supply_warning_flag_q;
		rdata_d[`LVSC_C1_WIE] = low_supply_warning_irq_enable_q;
		rdata_d[`LVSC_C1_DRE] = supply_detect_reset_enable;
		rdata_d[`LVSC_C1_DSE] = supply_detect_stop_enable_q;
		rdata_d[`LVSC_C1_DE] = supply_detect_enable;
		rdata_d[`LVSC_C1_REFERENCE_BUFFER_ENABLE] = reference_buffer_enable_q;
	end else if (addr_q == `LVSC_OFF_CTRL2) begin
		rdata_d[`LVSC_C2_DV] = supply_detect_level_select;
		rdata_d[`LVSC_C2_WV] = supply_warning_level_select_q;
		rdata_d[`LVSC_C2_PARTIAL_POWERDOWN_FLAG] = partial_powerdown_flag_q;
		rdata_d[`LVSC_C2_PARTIAL_POWERDOWN_CONTROL] = partial_powerdown_control;
	end else if (addr_q == `LVSC_OFF_ISTAT) begin
		rdata_d[`LVSC_IRQ_W-1:0] = istat_q;
	end else if (addr_q == `LVSC_OFF_IMASK) begin
		rdata_d[`LVSC_IRQ_W-1:0] = imask_q;
	end else if (addr_q == `LVSC_OFF_STATE) begin
		rdata_d[`LVSC_ST_W-1:0] = st_q;
	end
end

// Reads take one wait state so a write just before is visible
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h0000_0000;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
	end else begin
		hresp <= 1'b0;
		if (addr_phase && !hwrite) begin
			hreadyout <= 1'b0;
		end else if (rd_pend_q) begin
			hreadyout <= 1'b1;
			hrdata <= rdata_d;
		end else begin
			hreadyout <= 1'b1;
		end
	end
end

endmodule // lvsc_top
`default_nettype wire

// [lvsc_chk.sv]
// Port-level assertions for the supply supervisor
`default_nettype none
module lvsc_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire supply_warning_cmp,
	input wire supply_detect_cmp,
	input wire stop_request,
	input wire stop_wakeup,
	input wire supply_warning_irq,
	input wire supply_detect_reset,
	input wire stop2_active,
	input wire stop3_active,
	input wire supply_detect_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ********
	// Bus and mode properties
	// ********
	sequence s_rd;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_wr;
		hsel && htrans[1] && hready && hwrite;
	endsequence
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_resp;
		hresp == 1'b0;
	endproperty
	a_resp: assert property (p_resp) else $error("hresp not okay");
	property p_rd_wait;
		s_rd |=> s_wait;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_nowait;
		s_wr |=> hreadyout;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_stop_excl;
		!(stop2_active && stop3_active);
	endproperty
	a_stop_excl: assert property (p_stop_excl) else $error("two stop modes");
	property p_stop_entry;
		$rose(stop2_active || stop3_active) |-> $past(stop_request);
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop unasked");
	property p_stop2_exit;
		$fell(stop2_active) |-> $past(stop_wakeup);
	endproperty
	a_stop2_exit: assert property (p_stop2_exit) else $error("stop2 left");
	// Raw comparator must not reach outputs before the synchroniser
	property p_warn_sync;
		$rose(supply_warning_cmp) |=> !$rose(supply_warning_irq) [*2];
	endproperty
	a_warn_sync: assert property (p_warn_sync) else $error("warning unsynced");
	property p_det_sync;
		$rose(supply_detect_cmp) |=> !$rose(supply_detect_reset) [*2];
	endproperty
	a_det_sync: assert property (p_det_sync) else $error("detect unsynced");
	// Reset request and live flag come from the same edge, so they must agree
	property p_det_gate;
		supply_detect_reset |-> supply_detect_active;
	endproperty
	a_det_gate: assert property (p_det_gate) else $error("reset while detect off");
endmodule // lvsc_chk

bind lvsc_top lvsc_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .supply_warning_cmp, .supply_detect_cmp, .stop_request,
	.stop_wakeup, .supply_warning_irq, .supply_detect_reset, .stop2_active, .stop3_active,
	.supply_detect_active);
`default_nettype wire

// [lvsc_top_test.sv]
// Self-checking bench for the supply supervisor
`default_nettype none
module lvsc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic supply_warning_cmp = 1'b0;
	logic supply_detect_cmp = 1'b0;
	logic stop_request = 1'b0;
	logic stop_wakeup = 1'b0;
	logic [31:0] rd;
	wire [31:0] hrdata;
	wire [1:0] trip_select;
	wire hreadyout, hresp, supply_warning_irq, supply_detect_reset, reference_buffer_enable;
	wire supply_detect_active, stop2_active, stop3_active, irq;
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	always #2 hclk = ~hclk;
	lvsc_top u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .supply_warning_cmp,
		.supply_detect_cmp, .stop_request, .stop_wakeup, .supply_warning_irq,
		.supply_detect_reset, .reference_buffer_enable, .trip_select,
		.supply_detect_active, .stop2_active, .stop3_active, .irq
	);
	// ********
	// Bus tasks
	// ********
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		// Let the edge's register updates land before ports are looked at
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			finish_test;
		end
	end
	// ********
	// Tests
	// ********
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		tick(1);
		rc(8'h00, 32'h1c);
		rc(8'h04, 32'h0);
		rc(8'h10, 32'h0);
		rc(8'h14, 32'h0);
		chk(supply_detect_active, 32'h1); // detect on
		wr(8'h00, 32'h1d); // init write
		rc(8'h00, 32'h1d); // first write
		wr(8'h00, 32'h21);
		rc(8'h00, 32'h35); // bits locked
		wr(8'h04, 32'h31); // init write
		rc(8'h04, 32'h31); // stop2 chosen
		tick(2);
		chk(trip_select, 32'h3); // code 1:1
		wr(8'h04, 32'h0);
		rc(8'h04, 32'h21); // level locked
		tick(2);
		chk(trip_select, 32'h2); // code 1:0
		chk(reference_buffer_enable, 32'h1); // buffer on
		$display("test regs done");
		wr(8'h0c, 32'h1);
		supply_warning_cmp <= 1'b1;
		tick(6);
		chk(supply_warning_irq, 32'h1); // request raised
		chk(irq, 32'h1);
		rc(8'h00, 32'hb5); // flag set
		wr(8'h00, 32'h61);
		rc(8'h00, 32'hb5); // ack refused
		supply_warning_cmp <= 1'b0;
		tick(5);
		wr(8'h00, 32'h61);
		rc(8'h00, 32'h35); // ack taken
		chk(supply_warning_irq, 32'h0); // request gone
		rc(8'h08, 32'h1);
		wr(8'h08, 32'h1);
		tick(2);
		chk(irq, 32'h0);
		$display("test warning done");
		supply_detect_cmp <= 1'b1;
		tick(6);
		chk(supply_detect_reset, 32'h1); // reset forced
		supply_detect_cmp <= 1'b0;
		tick(6);
		chk(supply_detect_reset, 32'h0); // reset ends
		chk(irq, 32'h0);
		rc(8'h08, 32'h2);
		wr(8'h08, 32'h2);
		$display("test detect done");
		stop_request <= 1'b1;
		tick(1);
		stop_request <= 1'b0;
		tick(1);
		chk({stop3_active, stop2_active}, 32'h1); // stop2 entered
		chk(supply_detect_active, 32'h0); // off in stop
		rc(8'h10, 32'h2);
		stop_wakeup <= 1'b1;
		tick(1);
		stop_wakeup <= 1'b0;
		tick(1);
		chk(stop2_active, 32'h0);
		chk(supply_detect_active, 32'h1); // back on
		rc(8'h04, 32'h29); // flag after stop2
		rc(8'h08, 32'h4);
		wr(8'h0c, 32'h7);
		tick(2);
		chk(irq, 32'h1);
		wr(8'h08, 32'h4);
		tick(2);
		chk(irq, 32'h0);
		wr(8'h04, 32'h4); // ack after check
		rc(8'h04, 32'h21); // flag cleared
		$display("test stop done");
		hresetn <= 1'b0;
		tick(3);
		hresetn <= 1'b1;
		tick(1);
		chk(reference_buffer_enable, 32'h0); // off after reset
		chk(trip_select, 32'h0); // level unlocked
		rc(8'h00, 32'h1c); // reset values back
		wr(8'h04, 32'h0); // init write
		wr(8'h00, 32'h08); // init write
		wr(8'h00, 32'h0c);
		rc(8'h00, 32'h08); // detect stays off
		chk(supply_detect_active, 32'h0); // detect off
		supply_detect_cmp <= 1'b1;
		tick(6);
		chk(supply_detect_reset, 32'h0); // needs detect and reset enable
		supply_detect_cmp <= 1'b0;
		stop_request <= 1'b1;
		tick(1);
		stop_request <= 1'b0;
		tick(1);
		chk({stop3_active, stop2_active}, 32'h2); // stop3 entered
		chk(supply_detect_active, 32'h0); // needs detect enable
		rc(8'h10, 32'h1);
		stop_wakeup <= 1'b1;
		tick(1);
		stop_wakeup <= 1'b0;
		tick(1);
		chk(stop3_active, 32'h0);
		rc(8'h04, 32'h0); // no flag after stop3
		rc(8'h08, 32'h0);
		$display("test reset done");
		finish_test;
	end
endmodule // lvsc_top_test
`default_nettype wire
